// ==== verilog/hpi_pkg.sv ====
// Shared constants and carrier types for the host processor port block.
// Assumes one 125 MHz clock and the pin-level behaviour of the port.
package hpi_pkg;

  localparam int HPI_DATA_W = 8;
  localparam int HPI_ADDR_W = 10;
  localparam int HPI_SRC_N = 3;
  localparam int HPI_SRC_FRAMER = 0;
  localparam int HPI_SRC_LIU = 1;
  localparam int HPI_SRC_BERT = 2;
  localparam int HPI_SYNC_STAGES = 3;
  localparam int HPI_CLK_MHZ = 125;

  localparam logic HPI_MODE_PARALLEL = 1'h0;
  localparam logic HPI_MODE_SPI = 1'h1;
  localparam logic HPI_TIMING_SEPARATE = 1'h0;
  localparam logic HPI_TIMING_DIRSTROBE = 1'h1;

  localparam logic [HPI_DATA_W-1:0] HPI_DATA_RST = 8'h00;
  localparam logic [HPI_ADDR_W-1:0] HPI_ADDR_RST = 10'h000;
  localparam logic [HPI_SRC_N-1:0] HPI_PEND_RST = 3'h0;
  localparam logic [2:0] HPI_CTRL_RST = 3'h7;
  // Pin reset seen low and serial mode, so nothing moves before the pins.
  localparam logic [2:0] HPI_MODE_RST = 3'h1;

  // Active-low control pins as they arrive from the host.
  typedef struct packed {
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
  } hpi_ctrl_t;

  // One register write toward the device core.
  typedef struct packed {
    logic valid;
    logic [HPI_ADDR_W-1:0] addr;
    logic [HPI_DATA_W-1:0] data;
  } hpi_wr_t;

  typedef enum logic [1:0] {
    HPI_IDLE = 2'h0,
    HPI_READ = 2'h1,
    HPI_WRITE = 2'h2
  } hpi_state_t;

endpackage : hpi_pkg

// ==== verilog/hpi_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is quasi-static compared with three clock periods.
`timescale 1ns/100ps
module hpi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q, s2_q, s3_q, q_q;
  logic [W-1:0] s1_d, s2_d, s3_d, q_d;

  // Only the second stage looks at the first; the filter uses two and three.
  always_comb begin
    s1_d = d;
    s2_d = s1_q;
    s3_d = s2_q;
    q_d = q_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        q_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q_q <= RST_VAL;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule : hpi_sync

// ==== verilog/hpi_port.sv ====
// Host processor port control: strobe decode, register write and read
// hand-off to the core, interrupt output and device reset.
// Assumes an asynchronous host on the pins and a core on clk.
//
// Contract
// [R1] Chip select low: write strobe rise loads data into addressed register.
// [R2] Mode input 0 selects parallel port, 1 selects serial port.
// [R3] Drive open-drain interrupt low while any unmasked event is pending.
// [R4] Release interrupt only after every pending event is acknowledged; the code also releases it while pending events are masked.
// [R5] Global, framer, line interface and tester masks gate their sources.
// [R6] Timing select high: direction plus data strobe; low: separate strobes.
// [R7] Reset pin low resets registers, framer and line interface.
// [R8] Drive data while read and chip select low; float when chip select high.
// [R9] Host holds chip select low for every access.
// [R10] Host uses direction and strobe, or separate strobes, per timing.
// [R11] Strobes and chip select are synchronised before edges are acted upon.
`timescale 1ns/100ps
module hpi_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic device_reset_n,
  input wire logic bus_mode_select,
  input wire logic bus_timing_select,
  input wire hpi_pkg::hpi_ctrl_t ctrl_pins,
  input wire logic [hpi_pkg::HPI_ADDR_W-1:0] addr_pins,
  input wire logic [hpi_pkg::HPI_DATA_W-1:0] data_in,
  output logic [hpi_pkg::HPI_DATA_W-1:0] data_out,
  output logic data_oe,
  output hpi_pkg::hpi_wr_t reg_wr,
  output logic [hpi_pkg::HPI_ADDR_W-1:0] reg_rd_addr,
  input wire logic [hpi_pkg::HPI_DATA_W-1:0] reg_rdata,
  input wire logic [hpi_pkg::HPI_SRC_N-1:0] irq_event,
  input wire logic [hpi_pkg::HPI_SRC_N-1:0] irq_ack,
  input wire logic irq_mask_global,
  input wire logic [hpi_pkg::HPI_SRC_N-1:0] irq_mask,
  output logic interrupt_out_n,
  output logic interrupt_oe,
  output logic core_reset,
  output logic spi_mode
);
  import hpi_pkg::*;

  hpi_ctrl_t ctrl_f;
  logic rstn_f, bts_f, spi_f;
  logic [HPI_ADDR_W-1:0] addr_f;
  logic [HPI_DATA_W-1:0] data_f;
  logic srst;

  // Resynchronise everything from the pins; data and address follow the
  // same path so they line up with the filtered strobe edge. [R11]
  hpi_sync #(.W(3), .RST_VAL(HPI_CTRL_RST)) u_sync_ctrl (
    .clk(clk),
    .rst(rst),
    .d(ctrl_pins),
    .q(ctrl_f)
  );
  hpi_sync #(.W(3), .RST_VAL(HPI_MODE_RST)) u_sync_mode (
    .clk(clk),
    .rst(rst),
    .d({device_reset_n, bus_timing_select, bus_mode_select}),
    .q({rstn_f, bts_f, spi_f})
  );
  hpi_sync #(.W(HPI_ADDR_W + HPI_DATA_W)) u_sync_bus (
    .clk(clk),
    .rst(rst),
    .d({addr_pins, data_in}),
    .q({addr_f, data_f})
  );

  // Pin reset joins the system reset for all state of the port past the pin synchronisers. [R7]
  assign srst = rst | ~rstn_f;

  // Strobe decode. The second strobe pin is a direction line in
  // direction-plus-strobe timing; reads are high, writes low. [R6]
  logic rd_act, wr_act, par_sel;
  always_comb begin
    par_sel = (spi_f == HPI_MODE_PARALLEL) && !ctrl_f.chip_select_n; // [R2]
    if (bts_f == HPI_TIMING_DIRSTROBE) begin
      rd_act = !ctrl_f.read_strobe_n && ctrl_f.write_strobe_n; // [R6]
      wr_act = !ctrl_f.read_strobe_n && !ctrl_f.write_strobe_n; // [R6]
    end else begin
      rd_act = !ctrl_f.read_strobe_n; // [R6]
      wr_act = !ctrl_f.write_strobe_n; // [R6]
    end
  end

  hpi_state_t state_q, state_d;
  hpi_wr_t wr_q, wr_d;
  logic [HPI_DATA_W-1:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic [HPI_ADDR_W-1:0] raddr_q, raddr_d;

  // Writes commit when the strobe goes away with chip select still low;
  // an access abandoned by chip select alone is dropped. [R1]
  always_comb begin
    state_d = state_q;
    wr_d = '0;
    wr_d.addr = wr_q.addr;
    wr_d.data = wr_q.data;
    raddr_d = raddr_q;
    dout_d = dout_q;
    doe_d = 1'b0;
    unique case (state_q)
      HPI_IDLE: begin
        if (par_sel && wr_act) begin
          state_d = HPI_WRITE;
        end else if (par_sel && rd_act) begin
          state_d = HPI_READ;
          raddr_d = addr_f;
        end
      end
      HPI_READ: begin
        if (par_sel && rd_act) begin
          doe_d = 1'b1; // [R8]
          dout_d = reg_rdata; // [R8]
        end else begin
          state_d = HPI_IDLE;
        end
      end
      HPI_WRITE: begin
        if (!par_sel) begin
          state_d = HPI_IDLE;
        end else if (!wr_act) begin
          state_d = HPI_IDLE;
          wr_d.valid = 1'b1; // [R1]
          wr_d.addr = addr_f; // [R1]
          wr_d.data = data_f; // [R1]
        end
      end
      default: begin
        state_d = HPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= HPI_IDLE;
      wr_q <= '0;
      raddr_q <= HPI_ADDR_RST;
      dout_q <= HPI_DATA_RST;
      doe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wr_q <= wr_d;
      raddr_q <= raddr_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
    end
  end

  // Pending events stay until acknowledged; a new event beats its own
  // acknowledge in the same cycle. Masks gate only the pin, so unmasking
  // an already pending source raises the interrupt on the next clock. [R4] [R5]
  logic [HPI_SRC_N-1:0] pend_q, pend_d, live;
  logic irq_q, irq_d, core_rst_q, core_rst_d;
  always_comb begin
    pend_d = (pend_q & ~irq_ack) | irq_event; // [R4]
    live = pend_q & ~irq_mask; // [R5]
    irq_d = !irq_mask_global && (|live); // [R3] [R5]
    core_rst_d = srst; // [R7]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q <= HPI_PEND_RST;
      irq_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= core_rst_d;
    end
  end

  assign data_out = dout_q;
  assign data_oe = doe_q;
  assign reg_wr = wr_q;
  assign reg_rd_addr = raddr_q;
  assign interrupt_out_n = 1'b0;
  assign interrupt_oe = irq_q;
  assign core_reset = core_rst_q;
  assign spi_mode = spi_f;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence write_held_s;
    state_q == HPI_WRITE && par_sel && wr_act;
  endsequence
  sequence write_end_s;
    par_sel && !wr_act;
  endsequence

  write_commit_a: assert property (write_held_s ##1 write_end_s |=> // [R1]
    reg_wr.valid && reg_wr.data == $past(data_f))
    else $error("write not committed at strobe release");
  write_only_a: assert property (reg_wr.valid |-> // [R1]
    $past(state_q) == HPI_WRITE && $past(!ctrl_f.chip_select_n))
    else $error("write without chip select and strobe");
  serial_quiet_a: assert property ($past(spi_f) && spi_f |=> // [R2]
    !reg_wr.valid && !data_oe)
    else $error("parallel activity in serial mode");
  irq_raise_a: assert property ((|(pend_q & ~irq_mask)) && // [R3]
    !irq_mask_global |=> interrupt_oe && !interrupt_out_n)
    else $error("unmasked event not driving interrupt");
  irq_hold_a: assert property ($fell(interrupt_oe) |-> // [R4]
    $past(irq_mask_global) || !(|($past(pend_q) & ~$past(irq_mask))))
    else $error("interrupt released with event pending");
  irq_mask_a: assert property (irq_mask_global || // [R5]
    (pend_q & ~irq_mask) == 3'h0 |=> !interrupt_oe)
    else $error("masked source drove interrupt");
  dirstrobe_rd_a: assert property (bts_f && data_oe && // [R6]
    state_q == HPI_READ |-> $past(ctrl_f.write_strobe_n))
    else $error("read driven with direction set to write");
  cs_float_a: assert property (ctrl_f.chip_select_n |=> !data_oe) // [R8]
    else $error("data driven with chip select high");
  read_data_a: assert property (data_oe |-> // [R8]
    data_out == $past(reg_rdata))
    else $error("read data not from addressed register");
  pin_reset_a: assert property (disable iff (rst) !rstn_f |=> // [R7]
    core_reset && state_q == HPI_IDLE && pend_q == HPI_PEND_RST &&
    !interrupt_oe)
    else $error("reset pin did not reset port");

endmodule : hpi_port

// ==== verification/hpi_host.sv ====
// Host processor model: runs one register access on the port pins.
// Assumes one caller at a time and a bus with no pull resistor.
`timescale 1ns/100ps
module hpi_host (
  input wire logic clk,
  input wire logic timing,
  input wire logic [hpi_pkg::HPI_DATA_W-1:0] data_out,
  input wire logic data_oe,
  output hpi_pkg::hpi_ctrl_t ctrl_pins,
  output logic [hpi_pkg::HPI_ADDR_W-1:0] addr_pins,
  output logic [hpi_pkg::HPI_DATA_W-1:0] bus
);
  import hpi_pkg::*;
  logic drive_q;
  logic [HPI_DATA_W-1:0] wdata_q;
  // A released bus shows the inverse of the data last handed to access, never a stale copy.
  assign bus = data_oe ? data_out : (drive_q ? wdata_q : ~wdata_q);
  initial begin
    ctrl_pins = '1;
    addr_pins = '0;
    drive_q = 1'b0;
    wdata_q = '0;
  end
  task automatic access(input logic wr, input logic cs_en,
                        input logic [HPI_ADDR_W-1:0] a,
                        input logic [HPI_DATA_W-1:0] d,
                        output logic [HPI_DATA_W-1:0] rd);
    @(posedge clk);
    addr_pins <= a;
    wdata_q <= d;
    drive_q <= wr;
    ctrl_pins.chip_select_n <= ~cs_en;
    if (timing) ctrl_pins.write_strobe_n <= ~wr;
    repeat (2) @(posedge clk);
    if (timing || !wr) ctrl_pins.read_strobe_n <= 1'b0;
    else ctrl_pins.write_strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd = bus;
    ctrl_pins.read_strobe_n <= 1'b1;
    if (!timing) ctrl_pins.write_strobe_n <= 1'b1;
    // Address and data outlive the strobe because the pins are filtered.
    repeat (6) @(posedge clk);
    ctrl_pins <= '1;
    drive_q <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : access
endmodule : hpi_host

// ==== verification/hpi_port_tb.sv ====
// Self-checking bench for the host port with a host model on the pins.
// Assumes the core answers reads combinationally from the read address.
`timescale 1ns/100ps
module hpi_port_tb;
  import hpi_pkg::*;
  logic clk, rst, dev_rst_n, mode, timing, mask_g, doe, int_n, int_oe;
  logic core_rst, spi;
  logic [2:0] ev, ack, mask;
  hpi_ctrl_t ctrl;
  logic [9:0] addr, rd_addr;
  logic [7:0] din, dout, rdata, got;
  hpi_wr_t wr, wr_last;
  int num_errors = 0;
  int tests_run = 0;
  int wr_cnt = 0;
  int n;
  hpi_port dut (.clk(clk), .rst(rst), .device_reset_n(dev_rst_n),
    .bus_mode_select(mode), .bus_timing_select(timing), .ctrl_pins(ctrl),
    .addr_pins(addr), .data_in(din), .data_out(dout), .data_oe(doe),
    .reg_wr(wr), .reg_rd_addr(rd_addr), .reg_rdata(rdata), .irq_event(ev),
    .irq_ack(ack), .irq_mask_global(mask_g), .irq_mask(mask),
    .interrupt_out_n(int_n), .interrupt_oe(int_oe), .core_reset(core_rst),
    .spi_mode(spi));
  hpi_host host (.clk(clk), .timing(timing), .data_out(dout),
    .data_oe(doe), .ctrl_pins(ctrl), .addr_pins(addr), .bus(din));
  assign rdata = rd_addr[7:0] ^ 8'h5a;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr.valid === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= wr;
    end
  end
  task chk(input logic [17:0] g, input logic [17:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish;
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task wait_core;
    for (int i = 0; i < 50 && core_rst !== 1'b0; i++) @(posedge clk);
    chk(18'(core_rst), 18'h0);
    if (core_rst !== 1'b0) tally_and_finish;
  endtask : wait_core
  task pulse(input logic [2:0] e, input logic [2:0] a);
    @(posedge clk) begin
      ev <= e;
      ack <= a;
    end
    @(posedge clk) begin
      ev <= 3'h0;
      ack <= 3'h0;
    end
    repeat (4) @(posedge clk);
  endtask : pulse
  task t_access(input logic tm, input logic w);
    logic [9:0] a;
    a = 10'h2a5 ^ {9'h0, tm};
    @(posedge clk) timing <= tm;
    repeat (6) @(posedge clk);
    n = wr_cnt;
    host.access(w, 1'b1, a, a[7:0] ^ 8'h3c, got);
    chk(18'(wr_cnt - n), 18'(w));
    if (w) chk({wr_last.addr, wr_last.data}, {a, a[7:0] ^ 8'h3c});
    else chk(18'(got), 18'(a[7:0] ^ 8'h5a));
    chk(18'(doe), 18'h0);
  endtask : t_access
  task t_refuse;
    n = wr_cnt;
    host.access(1'b1, 1'b0, 10'h011, 8'h77, got);
    chk(18'(wr_cnt - n), 18'h0);
    @(posedge clk) mode <= 1'b1;
    repeat (6) @(posedge clk);
    chk(18'(spi), 18'h1);
    host.access(1'b1, 1'b1, 10'h012, 8'h78, got);
    chk(18'(wr_cnt - n), 18'h0);
    @(posedge clk) mode <= 1'b0;
    repeat (6) @(posedge clk);
    chk(18'(spi), 18'h0);
  endtask : t_refuse
  task t_irq;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) mask <= 3'h1 << i;
      pulse(3'h1 << i, 3'h0);
      chk(18'(int_oe), 18'h0);
      @(posedge clk) mask <= 3'h0;
      repeat (4) @(posedge clk);
      chk({17'(int_oe), int_n}, 18'h2);
      @(posedge clk) mask_g <= 1'b1;
      repeat (4) @(posedge clk);
      chk(18'(int_oe), 18'h0);
      @(posedge clk) mask_g <= 1'b0;
      pulse(3'h1 << ((i + 1) % 3), 3'h1 << i);
      chk(18'(int_oe), 18'h1);
      pulse(3'h0, 3'h1 << ((i + 1) % 3));
      chk(18'(int_oe), 18'h0);
    end
    // A fresh event must survive an acknowledge in the same cycle.
    pulse(3'h1, 3'h0);
    pulse(3'h1, 3'h1);
    chk(18'(int_oe), 18'h1);
    pulse(3'h0, 3'h1);
    chk(18'(int_oe), 18'h0);
  endtask : t_irq
  task t_reset;
    pulse(3'h1, 3'h0);
    @(posedge clk) dev_rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({17'(core_rst), int_oe}, 18'h2);
    @(posedge clk) dev_rst_n <= 1'b1;
    wait_core();
    chk(18'(int_oe), 18'h0);
  endtask : t_reset
  initial begin
    rst = 1'b1;
    dev_rst_n = 1'b1;
    {mode, timing, mask_g, ev, ack, mask} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_core();
    for (int k = 0; k < 4; k++) t_access(k[0], k[1]);
    t_refuse();
    t_irq();
    t_reset();
    t_access(1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : hpi_port_tb
